/* rtl/brf_pkg.sv */
// Package: constants for boot selection, code alias window and reset fetch
package brf_pkg;
  // ==========================================================================
  // Address map
  localparam logic [31:0] CODE_BASE      = 32'h0000_0000;
  localparam logic [31:0] CODE_TOP       = 32'h07FF_FFFF;
  localparam logic [31:0] SP_WORD_ADDR   = 32'h0000_0000;
  localparam logic [31:0] PC_WORD_ADDR   = 32'h0000_0004;
  localparam logic [31:0] FLASH_BASE     = 32'h0800_0000;
  localparam logic [31:0] BOOTCODE_BASE  = 32'h1FFF_B000;
  localparam logic [31:0] SRAM_BASE      = 32'h2000_0000;
  // ==========================================================================
  // Boot pin patterns {upper, lower}
  localparam logic [1:0]  PAT_FLASH_A    = 2'h0;
  localparam logic [1:0]  PAT_BOOTCODE   = 2'h1;
  localparam logic [1:0]  PAT_FLASH_B    = 2'h2;
  localparam logic [1:0]  PAT_SRAM       = 2'h3;
  // ==========================================================================
  // Reset values and synchroniser depth
  localparam logic [1:0]  BOOT_SEL_RST   = 2'h0;
  localparam logic [31:0] WORD_RST       = 32'h0000_0000;
  localparam int          SYNC_STAGES    = 3;
  // ==========================================================================
  // Types
  typedef enum logic [1:0] {SEL_FLASH, SEL_BOOTCODE, SEL_SRAM} brf_mem_e;
  typedef enum logic [2:0] {ST_LATCH, ST_REQ_SP, ST_WAIT_SP, ST_REQ_PC, ST_WAIT_PC,
                            ST_RUN} brf_state_e;
endpackage

/* rtl/brf_pin_sync.sv */
// Module: three-stage synchroniser for the boot-select pins
`timescale 1ns/100ps
module brf_pin_sync #(
  parameter int WIDTH = 2
) (
  input  wire logic             CLOCK,
  input  wire logic             RST,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_out,
  output logic                  settled
);
  // ==========================================================================
  // Stages
  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;

  if (WIDTH < 1) begin : g_chk_width
    $error("brf_pin_sync: WIDTH must be at least 1");
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Value counts once second and third stages agree
  assign pin_out = s3_q;
  assign settled = (s2_q == s3_q);
endmodule // brf_pin_sync

/* rtl/brf_boot_remap.sv */
// Module: boot pin latch, code-window remap and reset word fetch
`timescale 1ns/100ps
// Contract
// - Pins 00 or 10 map main flash into the code region.
// - Pins 01 map built-in boot code into the code region.
// - Pins 11 map on-chip SRAM into the code region.
// - Alias window spans code bottom through code top inclusive.
// - Pins relatched on each system reset and standby exit, held between; here a standby exit acts only once the core runs (ST_RUN).
// - After reset, fetch two consecutive words before any instruction runs.
// - First word, at code bottom, becomes initial main stack pointer.
// - Second word becomes reset vector; image stores it with bit zero set.
// - Vector table starts at the reset vector word, right after stack word.
module brf_boot_remap (
  input  wire logic        CLOCK,
  input  wire logic        RST,
  input  wire logic        STANDBY_EXIT,
  input  wire logic        BOOT_SELECT_UPPER_PIN,
  input  wire logic        BOOT_SELECT_LOWER_PIN,
  input  wire logic [31:0] CPU_ADDR,
  input  wire logic        CPU_VALID,
  input  wire logic        FETCH_READY,
  input  wire logic [31:0] FETCH_RDATA,
  output logic      [31:0] MEM_ADDR,
  output logic             MEM_VALID,
  output logic      [1:0]  BOOT_SEL,
  output logic      [31:0] MAIN_STACK_POINTER,
  output logic      [31:0] RESET_VECTOR,
  output logic      [31:0] VECTOR_TABLE_BASE,
  output logic             VECTOR_LSB_BAD,
  output logic             CPU_RUN
);
  // ==========================================================================
  // Pin synchronisation
  logic [1:0] pins_sync;
  logic       pins_settled;

  brf_pin_sync #(
    .WIDTH (2)
  ) u_sync (
    .CLOCK   (CLOCK),
    .RST     (RST),
    .pin_in  ({BOOT_SELECT_UPPER_PIN, BOOT_SELECT_LOWER_PIN}),
    .pin_out (pins_sync),
    .settled (pins_settled)
  );

  // ==========================================================================
  // Decode helpers
  function automatic brf_pkg::brf_mem_e decode_pins(input logic [1:0] p);
    brf_pkg::brf_mem_e m;
    m = brf_pkg::SEL_FLASH;
    if (p == brf_pkg::PAT_BOOTCODE) m = brf_pkg::SEL_BOOTCODE;
    if (p == brf_pkg::PAT_SRAM)     m = brf_pkg::SEL_SRAM;
    return m;
  endfunction

  function automatic logic [31:0] remap(input logic [31:0] a, input brf_pkg::brf_mem_e m);
    logic [31:0] base;
    logic [31:0] r;
    base = brf_pkg::FLASH_BASE;
    if (m == brf_pkg::SEL_BOOTCODE) base = brf_pkg::BOOTCODE_BASE;
    if (m == brf_pkg::SEL_SRAM)     base = brf_pkg::SRAM_BASE;
    r = a;
    if (a <= brf_pkg::CODE_TOP)
      r = base + (a - brf_pkg::CODE_BASE);
    return r;
  endfunction

  // ==========================================================================
  // State
  brf_pkg::brf_state_e state_q, state_d;
  brf_pkg::brf_mem_e   sel_q;
  logic [1:0]          pins_q;
  logic [31:0]         msp_q;
  logic [31:0]         rv_q;
  logic [31:0]         mem_addr_q;
  logic                mem_valid_q;
  logic                lsb_bad_q;
  logic                run_q;
  logic [1:0]          fill_q;
  logic [31:0]         vtb_q;

  // ==========================================================================
  // Elaboration checks
  if (brf_pkg::SYNC_STAGES != 3) begin : g_chk_sync
    $error("brf_boot_remap: the pin synchroniser has exactly three stages");
  end
  if (brf_pkg::SP_WORD_ADDR != brf_pkg::CODE_BASE) begin : g_chk_sp
    $error("brf_boot_remap: stack word must sit at the bottom of the code window");
  end
  if (brf_pkg::PC_WORD_ADDR != brf_pkg::SP_WORD_ADDR + 32'h0000_0004) begin : g_chk_pc
    $error("brf_boot_remap: reset vector word must follow the stack word");
  end
  if (brf_pkg::CODE_TOP <= brf_pkg::PC_WORD_ADDR) begin : g_chk_window
    $error("brf_boot_remap: code window too small for the reset words");
  end
  if (brf_pkg::FLASH_BASE <= brf_pkg::CODE_TOP ||
      brf_pkg::BOOTCODE_BASE <= brf_pkg::CODE_TOP ||
      brf_pkg::SRAM_BASE <= brf_pkg::CODE_TOP) begin : g_chk_bases
    $error("brf_boot_remap: memory bases must lie above the code window");
  end

  // ==========================================================================
  // Named decodes
  wire relatch   = STANDBY_EXIT;
  wire fill_done = (fill_q == 2'(brf_pkg::SYNC_STAGES));
  wire latch_now = (state_q == brf_pkg::ST_LATCH) && fill_done && pins_settled;
  wire fetch_ack = FETCH_READY && mem_valid_q;
  wire sp_phase  = (state_q == brf_pkg::ST_REQ_SP) || (state_q == brf_pkg::ST_WAIT_SP);
  wire pc_phase  = (state_q == brf_pkg::ST_REQ_PC) || (state_q == brf_pkg::ST_WAIT_PC);
  wire cpu_req   = (state_q == brf_pkg::ST_RUN) && CPU_VALID;
  wire take_sp   = (state_q == brf_pkg::ST_WAIT_SP) && fetch_ack;
  wire take_pc   = (state_q == brf_pkg::ST_WAIT_PC) && fetch_ack;

  // Address the fetch engine or the core presents
  wire [31:0] req_addr = sp_phase ? brf_pkg::SP_WORD_ADDR :
                         pc_phase ? brf_pkg::PC_WORD_ADDR : CPU_ADDR;
  wire        req_on   = sp_phase || pc_phase || cpu_req;
  // A taken fetch word drops the request for one cycle before the next word
  wire        req_next = req_on && !(take_sp || take_pc);

  // ==========================================================================
  // Sequencer
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      brf_pkg::ST_LATCH:   if (latch_now) state_d = brf_pkg::ST_REQ_SP;
      brf_pkg::ST_REQ_SP:  state_d = brf_pkg::ST_WAIT_SP;
      brf_pkg::ST_WAIT_SP: if (fetch_ack) state_d = brf_pkg::ST_REQ_PC;
      brf_pkg::ST_REQ_PC:  state_d = brf_pkg::ST_WAIT_PC;
      brf_pkg::ST_WAIT_PC: if (fetch_ack) state_d = brf_pkg::ST_RUN;
      brf_pkg::ST_RUN:     if (relatch) state_d = brf_pkg::ST_LATCH;
      default:             state_d = brf_pkg::ST_LATCH;
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      state_q <= brf_pkg::ST_LATCH;
      run_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      run_q   <= (state_d == brf_pkg::ST_RUN);
    end
  end

  // ==========================================================================
  // Synchroniser fill
  // Reset clears the stages, so they agree before the pins have reached them;
  // the latch waits until every stage holds a sampled pin level
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      fill_q <= '0;
    end else if (!fill_done) begin
      fill_q <= fill_q + 2'h1;
    end
  end

  // Selection latch, held between reset and standby exit
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      pins_q <= brf_pkg::BOOT_SEL_RST;
      sel_q  <= brf_pkg::SEL_FLASH;
    end else if (latch_now) begin
      pins_q <= pins_sync;
      sel_q  <= decode_pins(pins_sync);
    end
  end

  // Captured reset words
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      msp_q     <= brf_pkg::WORD_RST;
      rv_q      <= brf_pkg::WORD_RST;
      lsb_bad_q <= 1'b0;
    end else begin
      if (take_sp) begin
        msp_q <= FETCH_RDATA;
      end
      // A clear bit zero is flagged, not blocked: the core still starts
      if (take_pc) begin
        rv_q      <= FETCH_RDATA;
        lsb_bad_q <= ~FETCH_RDATA[0];
      end
    end
  end

  // Registered memory request
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      mem_addr_q  <= brf_pkg::WORD_RST;
      mem_valid_q <= 1'b0;
    end else begin
      mem_addr_q  <= remap(req_addr, sel_q);
      mem_valid_q <= req_next;
    end
  end

  // Vector table base, registered like every other output
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      vtb_q <= brf_pkg::PC_WORD_ADDR;
    end else begin
      vtb_q <= brf_pkg::PC_WORD_ADDR;
    end
  end

  // ==========================================================================
  // Outputs
  assign MEM_ADDR           = mem_addr_q;
  assign MEM_VALID          = mem_valid_q;
  assign BOOT_SEL           = pins_q;
  assign MAIN_STACK_POINTER = msp_q;
  assign RESET_VECTOR       = rv_q;
  assign VECTOR_TABLE_BASE  = vtb_q;
  assign VECTOR_LSB_BAD     = lsb_bad_q;
  assign CPU_RUN            = run_q;
endmodule // brf_boot_remap

/* testbench/brf_boot_remap_monitor.sv */
// Checker: port-level assertions for the boot remap and reset fetch block
`timescale 1ns/100ps
module brf_boot_remap_monitor (
  input wire logic        CLOCK,
  input wire logic        RST,
  input wire logic        STANDBY_EXIT,
  input wire logic [31:0] CPU_ADDR,
  input wire logic        CPU_VALID,
  input wire logic        FETCH_READY,
  input wire logic [31:0] FETCH_RDATA,
  input wire logic [31:0] MEM_ADDR,
  input wire logic        MEM_VALID,
  input wire logic [1:0]  BOOT_SEL,
  input wire logic [31:0] MAIN_STACK_POINTER,
  input wire logic [31:0] RESET_VECTOR,
  input wire logic [31:0] VECTOR_TABLE_BASE,
  input wire logic        VECTOR_LSB_BAD,
  input wire logic        CPU_RUN
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);
  // ==========================================================================
  // Helpers
  wire logic [31:0] sel_base = (BOOT_SEL == brf_pkg::PAT_SRAM) ? brf_pkg::SRAM_BASE :
    (BOOT_SEL == brf_pkg::PAT_BOOTCODE) ? brf_pkg::BOOTCODE_BASE : brf_pkg::FLASH_BASE;
  wire logic        done   = MEM_VALID && FETCH_READY && !CPU_RUN;
  wire logic        cpu_go = CPU_RUN && CPU_VALID && !STANDBY_EXIT;
  wire logic        rd_lsb = FETCH_RDATA[0];
  // ==========================================================================
  // Properties
  property p_remap;
    cpu_go && CPU_ADDR <= brf_pkg::CODE_TOP |=> MEM_ADDR == sel_base + $past(CPU_ADDR);
  endproperty
  a_remap: assert property (p_remap) else $error("alias address wrong");
  property p_outside;
    cpu_go && CPU_ADDR > brf_pkg::CODE_TOP |=> MEM_ADDR == $past(CPU_ADDR);
  endproperty
  a_outside: assert property (p_outside) else $error("outside window remapped");
  property p_sp;
    done && MEM_ADDR == sel_base |=> MAIN_STACK_POINTER == $past(FETCH_RDATA);
  endproperty
  a_sp: assert property (p_sp) else $error("stack word not loaded");
  property p_pc;
    done && MEM_ADDR == sel_base + brf_pkg::PC_WORD_ADDR |=>
      RESET_VECTOR == $past(FETCH_RDATA) && CPU_RUN;
  endproperty
  a_pc: assert property (p_pc) else $error("vector word not loaded");
  property p_lsb;
    done && MEM_ADDR == sel_base + brf_pkg::PC_WORD_ADDR |=> VECTOR_LSB_BAD == !$past(rd_lsb);
  endproperty
  a_lsb: assert property (p_lsb) else $error("vector bit zero flag wrong");
  property p_start;
    $rose(CPU_RUN) |-> $past(done);
  endproperty
  a_start: assert property (p_start) else $error("run without fetch");
  property p_vtb;
    VECTOR_TABLE_BASE == brf_pkg::PC_WORD_ADDR;
  endproperty
  a_vtb: assert property (p_vtb) else $error("vector table base wrong");
  property p_hold;
    CPU_RUN && !STANDBY_EXIT |=> $stable(BOOT_SEL);
  endproperty
  a_hold: assert property (p_hold) else $error("boot selection changed");
endmodule // brf_boot_remap_monitor

bind brf_boot_remap brf_boot_remap_monitor u_mon (
  .CLOCK              (CLOCK),
  .RST                (RST),
  .STANDBY_EXIT       (STANDBY_EXIT),
  .CPU_ADDR           (CPU_ADDR),
  .CPU_VALID          (CPU_VALID),
  .FETCH_READY        (FETCH_READY),
  .FETCH_RDATA        (FETCH_RDATA),
  .MEM_ADDR           (MEM_ADDR),
  .MEM_VALID          (MEM_VALID),
  .BOOT_SEL           (BOOT_SEL),
  .MAIN_STACK_POINTER (MAIN_STACK_POINTER),
  .RESET_VECTOR       (RESET_VECTOR),
  .VECTOR_TABLE_BASE  (VECTOR_TABLE_BASE),
  .VECTOR_LSB_BAD     (VECTOR_LSB_BAD),
  .CPU_RUN            (CPU_RUN)
);

/* testbench/brf_image_model.sv */
// Memory and firmware image model answering the reset word fetch
`timescale 1ns/100ps
module brf_image_model (
  input  wire logic        CLOCK,
  input  wire logic        RST,
  input  wire logic [31:0] MEM_ADDR,
  input  wire logic        MEM_VALID,
  input  wire logic        SLOW,
  input  wire logic        BAD_LSB,
  output logic             FETCH_READY,
  output logic      [31:0] FETCH_RDATA
);
  logic [1:0] wait_q;
  wire logic [31:0] word = MEM_ADDR ^ 32'h0000_0101 ^ {31'h0, BAD_LSB & MEM_ADDR[2]};
  assign FETCH_RDATA = FETCH_READY ? word : ~word;
  always_ff @(posedge CLOCK) begin
    if (RST || !MEM_VALID || FETCH_READY) begin
      wait_q      <= 2'h0;
      FETCH_READY <= 1'b0;
    end else begin
      wait_q      <= wait_q + 2'h1;
      FETCH_READY <= !SLOW || wait_q == 2'h3;
    end
  end
endmodule // brf_image_model

/* testbench/tb_boot_remap_reset_fetch.sv */
// Testbench: boot selection, reset word fetch and code window remap
`timescale 1ns/100ps
module tb_boot_remap_reset_fetch;
  logic        CLOCK = 1'b0;
  logic        RST = 1'b1;
  logic        STANDBY_EXIT = 1'b0;
  logic [1:0]  pins = 2'h0;
  logic [31:0] CPU_ADDR = 32'h0;
  logic        CPU_VALID = 1'b0;
  logic        slow = 1'b0;
  logic        bad = 1'b0;
  logic        rdy, mvld, lsb_bad, run;
  logic [31:0] rdata, maddr, main_stack_pointer, rv, vtb;
  logic [1:0]  sel;
  int          fails = 0;
  int          compares = 0;
  int          cyc = 0;
  always #4 CLOCK = ~CLOCK;
  brf_boot_remap u_dut (.CLOCK(CLOCK), .RST(RST), .STANDBY_EXIT(STANDBY_EXIT),
    .BOOT_SELECT_UPPER_PIN(pins[1]), .BOOT_SELECT_LOWER_PIN(pins[0]), .CPU_ADDR(CPU_ADDR),
    .CPU_VALID(CPU_VALID), .FETCH_READY(rdy), .FETCH_RDATA(rdata), .MEM_ADDR(maddr),
    .MEM_VALID(mvld), .BOOT_SEL(sel), .MAIN_STACK_POINTER(main_stack_pointer), .RESET_VECTOR(rv),
    .VECTOR_TABLE_BASE(vtb), .VECTOR_LSB_BAD(lsb_bad), .CPU_RUN(run));
  brf_image_model u_img (.CLOCK(CLOCK), .RST(RST), .MEM_ADDR(maddr), .MEM_VALID(mvld),
    .SLOW(slow), .BAD_LSB(bad), .FETCH_READY(rdy), .FETCH_RDATA(rdata));
  // ==========================================================================
  // Checking and closing
  task automatic report_and_stop();
    if (fails == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  always @(posedge CLOCK) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      fails++;
      report_and_stop();
    end
  end
  function automatic logic [31:0] base_of(logic [1:0] p);
    return (p == 2'h3) ? brf_pkg::SRAM_BASE :
           (p == 2'h1) ? brf_pkg::BOOTCODE_BASE : brf_pkg::FLASH_BASE;
  endfunction
  // ==========================================================================
  // Bus tasks
  task automatic wait_run();
    int n = 0;
    while (run !== 1'b1 && n < 100) begin
      @(negedge CLOCK);
      n++;
    end
  endtask
  task automatic check_boot(logic [1:0] p, logic b);
    check("boot_sel", {30'h0, sel}, {30'h0, p});
    check("cpu_run", {31'h0, run}, 32'h1);
    check("stack", main_stack_pointer, base_of(p) ^ 32'h101);
    check("vector", rv, (base_of(p) + 32'h4) ^ 32'h101 ^ {31'h0, b});
    check("lsb_bad", {31'h0, lsb_bad}, {31'h0, b});
    check("vt_base", vtb, 32'h0000_0004);
  endtask
  task automatic boot(logic [1:0] p, logic s, logic b);
    pins = p;
    slow = s;
    bad  = b;
    RST  = 1'b1;
    repeat (3) @(negedge CLOCK);
    RST = 1'b0;
    wait_run();
    check_boot(p, b);
  endtask
  task automatic access(logic [31:0] a, logic [31:0] e);
    CPU_ADDR  = a;
    CPU_VALID = 1'b1;
    @(negedge CLOCK);
    check("mem_valid", {31'h0, mvld}, 32'h1);
    CPU_VALID = 1'b0;
    @(negedge CLOCK);
    check("mem_addr", maddr, e);
  endtask
  // ==========================================================================
  // Scenarios
  task automatic scen_modes();
    for (int p = 0; p < 4; p++) begin
      boot(p[1:0], p[0], 1'b0);
      access(32'h0000_0010, base_of(p[1:0]) + 32'h10);
      access(32'h07FF_FFFC, base_of(p[1:0]) + 32'h07FF_FFFC);
      access(32'h0800_0010, 32'h0800_0010);
    end
  endtask
  task automatic scen_relatch();
    boot(2'h1, 1'b0, 1'b1);
    pins = 2'h3;
    bad  = 1'b0;
    repeat (10) @(negedge CLOCK);
    check("held_sel", {30'h0, sel}, 32'h1);
    STANDBY_EXIT = 1'b1;
    @(negedge CLOCK);
    STANDBY_EXIT = 1'b0;
    repeat (3) @(negedge CLOCK);
    wait_run();
    check_boot(2'h3, 1'b0);
  endtask
  initial begin
    repeat (12) @(negedge CLOCK);
    scen_modes();
    scen_relatch();
    report_and_stop();
  end
endmodule // tb_boot_remap_reset_fetch
